// ---- hw/asr_consts.vh ----
// Constants for the asynchronous serial receiver block
`ifndef ASR_CONSTS_VH
`define ASR_CONSTS_VH
// Register word offsets (byte address = offset, word aligned)
`define ASR_ADR_BAUD_CTRL   8'h00
`define ASR_ADR_INT_CTRL    8'h04
`define ASR_ADR_IRQ_EN1     8'h08
`define ASR_ADR_IRQ_FLG1    8'h0C
`define ASR_ADR_RX_DATA     8'h10
`define ASR_ADR_RX_STAT     8'h14
`define ASR_ADR_DIV_LO      8'h18
`define ASR_ADR_DIV_HI      8'h1C
`define ASR_ADR_TX_STAT     8'h20
// Transmit status/control fields
`define ASR_TX_CLOCK_SOURCE_SELECT  7
`define ASR_TX_TX9   6
`define ASR_TX_TRANSMITTER_ENABLE  5
`define ASR_TX_SYNC  4
`define ASR_TX_BRK   3
`define ASR_TX_HIGH_SPEED_SELECT  2
`define ASR_TX_SHIFTER_EMPTY_STATUS  1
`define ASR_TX_TX_NINTH_BIT  0
// Receive status/control fields
`define ASR_RX_PORT_ENABLE  7
`define ASR_RX_RX9   6
`define ASR_RX_SINGLE_RX_ENABLE  5
`define ASR_RX_CONTINUOUS_RX_ENABLE  4
`define ASR_RX_ADEN  3
`define ASR_RX_FRAMING_ERROR_FLAG  2
`define ASR_RX_OVERRUN_FLAG  1
`define ASR_RX_RX_NINTH_BIT  0
// Interrupt and baud-control fields
`define ASR_IC_GIE   7
`define ASR_IC_PERIPHERAL_IRQ_ENABLE  6
`define ASR_IE_RX_IRQ_ENABLE  5
`define ASR_FL_RX_PENDING_FLAG  5
`define ASR_BC_IDLE  6
`define ASR_BC_WIDE  3
// Reset values
`define ASR_TX_RST   8'h02
`define ASR_BC_RST   8'h40
// Oversampling
`define ASR_OVS      16
`define ASR_OVS_HALF 4'h7
`define ASR_OVS_LAST 4'hF
`endif

// ---- hw/asr_top.v ----
// Asynchronous serial receiver with its control registers on Wishbone
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "asr_consts.vh"
// Functional notes
// - Character into buffer sets pending flag; irq needs enable and both globals
// - Transmit control bit 4 selects sync (1) or async (0) mode
// - Nine-bit receive select makes the receiver capture a ninth bit
// - Nine-bit address detect keeps only characters with ninth bit one
// - Characters accepted under nine-bit address detect report ninth bit one
// - With address detect cleared every character is buffered and flagged
// - Bit 7 picks sync master or slave clock; ignored in async
// - Bit 6 selects nine-bit transmit
// - Bit 5 enables the transmitter
// - Bit 3 requests break in async mode; hardware clears it after
// - Bit 2 selects high-speed baud scaling in async mode; here it only drives O_HIGH_SPEED, the divisor ignores it
// - Read-only bit 1 shows shifter empty, one after reset
// - Bit 0 holds the ninth transmit bit
// - In sync mode receive enables override transmit enable
// - Two-deep buffer; third character sets overrun and stops reception
// - Bit recovery at sixteen samples per bit
// - Start edge rechecked at half bit; high aborts silently
// - Stop bit zero sets framing error for that character
module asr_top #(
  parameter DEPTH = 2
) (
  // Clock and reset
  input  wire        I_REF_CLK,
  input  wire        I_RST_N,
  // Wishbone slave
  input  wire        I_WB_CYC,
  input  wire        I_WB_STB,
  input  wire        I_WB_WE,
  input  wire [7:0]  I_WB_ADR,
  input  wire [3:0]  I_WB_SEL,
  input  wire [31:0] I_WB_DAT,
  output reg  [31:0] O_WB_DAT,
  output reg         O_WB_ACK,
  // Serial line and control outputs
  input  wire        I_RX,
  output wire        O_IRQ,
  output wire        O_TX_ENABLE,
  output wire        O_SYNC_MASTER,
  output wire        O_HIGH_SPEED
);

  localparam S_IDLE  = 2'b00;
  localparam S_START = 2'b01;
  localparam S_DATA  = 2'b10;
  localparam S_STOP  = 2'b11;

  reg  [7:0]  txc_q;
  reg  [7:0]  rxc_q;
  reg  [7:0]  baud_q;
  reg  [7:0]  intc_q;
  reg  [7:0]  ien_q;
  reg  [7:0]  div_lo_q;
  reg  [7:0]  div_hi_q;
  reg  [15:0] brg_q;
  reg         tick_q;
  reg  [1:0]  rx_sync_q;
  reg         rx_prev_q;
  reg  [1:0]  st_q;
  reg  [3:0]  ovs_q;
  reg  [3:0]  bit_q;
  reg  [8:0]  shf_q;
  reg  [2:0]  maj_q;
  reg  [9:0]  mem_q [0:DEPTH-1];
  reg         rd_ptr_q;
  reg         wr_ptr_q;
  reg  [1:0]  cnt_q;
  reg         overrun_flag_q;
  wire        port_enable;
  wire        rx_on;
  wire        rx_in;
  wire        wb_req;
  wire        wr;
  wire        rd;
  wire [9:0]  top;
  wire        pend;
  wire        maj;
  wire [3:0]  nbits;
  wire        push_ok;
  wire        pop;
  wire [15:0] brg_max;
  // Receive path and tick control
  wire        brg_clr;
  wire        stop_done;
  wire        keep;
  wire        full;
  wire        over;
  wire        rx_idle;
  wire [7:0]  rx_stat;
  // Register write strobes
  wire        wr_txc;
  wire        wr_rxc;
  wire        wr_baud;
  wire        wr_intc;
  wire        wr_ien;
  wire        wr_dlo;
  wire        wr_dhi;

  function hit;
    input [7:0] a;
    input [7:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  assign port_enable    = rxc_q[`ASR_RX_PORT_ENABLE];
  assign rx_on   = port_enable & rxc_q[`ASR_RX_CONTINUOUS_RX_ENABLE] & ~txc_q[`ASR_TX_SYNC];
  assign rx_in   = rx_sync_q[1];
  assign wb_req  = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign wr      = wb_req & I_WB_WE & I_WB_SEL[0];
  assign rd      = wb_req & ~I_WB_WE;
  assign top     = mem_q[rd_ptr_q];
  assign pend    = (cnt_q != 2'b00);
  assign maj     = (maj_q[0] & maj_q[1]) | (maj_q[1] & maj_q[2])
                 | (maj_q[0] & maj_q[2]);
  assign nbits   = rxc_q[`ASR_RX_RX9] ? 4'h9 : 4'h8;
  assign pop     = rd & hit(I_WB_ADR, `ASR_ADR_RX_DATA) & pend;
  assign O_IRQ   = pend & ien_q[`ASR_IE_RX_IRQ_ENABLE] & intc_q[`ASR_IC_PERIPHERAL_IRQ_ENABLE]
                 & intc_q[`ASR_IC_GIE];
  // Sync mode receive enables take priority over transmit enable
  assign O_TX_ENABLE = txc_q[`ASR_TX_TRANSMITTER_ENABLE] & ~(txc_q[`ASR_TX_SYNC] &
                       (rxc_q[`ASR_RX_CONTINUOUS_RX_ENABLE] | rxc_q[`ASR_RX_SINGLE_RX_ENABLE]));
  assign O_SYNC_MASTER = txc_q[`ASR_TX_SYNC] & txc_q[`ASR_TX_CLOCK_SOURCE_SELECT];
  assign O_HIGH_SPEED  = ~txc_q[`ASR_TX_SYNC] & txc_q[`ASR_TX_HIGH_SPEED_SELECT];
  // Divisor n gives 16x tick every n+1 clocks whether or not high-speed is set
  // (that bit only drives O_HIGH_SPEED); narrow mode uses the low byte
  assign brg_max = baud_q[`ASR_BC_WIDE] ? {div_hi_q, div_lo_q}
                 : {8'h00, div_lo_q};

  // Per-register write strobes; only the low byte lane carries data
  assign wr_txc  = wr & hit(I_WB_ADR, `ASR_ADR_TX_STAT);
  assign wr_rxc  = wr & hit(I_WB_ADR, `ASR_ADR_RX_STAT);
  assign wr_baud = wr & hit(I_WB_ADR, `ASR_ADR_BAUD_CTRL);
  assign wr_intc = wr & hit(I_WB_ADR, `ASR_ADR_INT_CTRL);
  assign wr_ien  = wr & hit(I_WB_ADR, `ASR_ADR_IRQ_EN1);
  assign wr_dlo  = wr & hit(I_WB_ADR, `ASR_ADR_DIV_LO);
  assign wr_dhi  = wr & hit(I_WB_ADR, `ASR_ADR_DIV_HI);
  // A new divisor restarts the tick count so it takes effect at once
  assign brg_clr = !port_enable | wr_dlo | wr_dhi;
  assign rx_idle = (st_q == S_IDLE);

  // The stop-bit sample point ends every frame
  assign stop_done = tick_q & (st_q == S_STOP) & (ovs_q == `ASR_OVS_LAST);
  // Address mode drops data characters outright
  assign keep      = ~(rxc_q[`ASR_RX_RX9] & rxc_q[`ASR_RX_ADEN]
                     & ~shf_q[8]);
  // Count reaches the depth when every slot holds a character
  assign full      = (cnt_q == DEPTH);
  // A pop in the same cycle frees a slot, so a full buffer still takes it
  assign push_ok   = stop_done & keep & (~full | pop);
  assign over      = stop_done & keep & full & ~pop;
  // Top character's framing error and ninth bit; zero when empty
  assign rx_stat   = {rxc_q[7:3], pend & top[9], overrun_flag_q,
                      pend & top[8]};

  // Input synchroniser
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
      rx_sync_q <= 2'b11;
    else
      rx_sync_q <= {rx_sync_q[0], I_RX};
  end

  // Oversampling tick generator
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N || brg_clr)
    begin
      brg_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else if (brg_q >= brg_max)
    begin
      brg_q  <= 16'h0000;
      tick_q <= 1'b1;
    end
    else
    begin
      brg_q  <= brg_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

  // Receive sequencer and shift register
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N || !port_enable)
    begin
      st_q      <= S_IDLE;
      ovs_q     <= 4'h0;
      bit_q     <= 4'h0;
      shf_q     <= 9'h000;
      maj_q     <= 3'b111;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      if (tick_q)
      begin
        rx_prev_q <= rx_in;
        maj_q     <= {maj_q[1:0], rx_in};
        case (st_q)
          S_IDLE:
          begin
            if (rx_on && !overrun_flag_q && rx_prev_q && !rx_in)
            begin
              st_q  <= S_START;
              ovs_q <= 4'h0;
            end
          end
          S_START:
          begin
            if (ovs_q == `ASR_OVS_HALF)
            begin
              ovs_q <= 4'h0;
              bit_q <= 4'h0;
              st_q  <= rx_in ? S_IDLE : S_DATA;
            end
            else
              ovs_q <= ovs_q + 4'h1;
          end
          S_DATA:
          begin
            if (ovs_q == `ASR_OVS_LAST)
            begin
              ovs_q <= 4'h0;
              // LSB first into the top of the frame window
              shf_q <= rxc_q[`ASR_RX_RX9] ? {maj, shf_q[8:1]}
                                           : {1'b0, maj, shf_q[7:1]};
              bit_q <= bit_q + 4'h1;
              if (bit_q == nbits - 4'h1)
                st_q <= S_STOP;
            end
            else
              ovs_q <= ovs_q + 4'h1;
          end
          S_STOP:
          begin
            if (ovs_q == `ASR_OVS_LAST)
            begin
              st_q  <= S_IDLE;
              ovs_q <= 4'h0;
            end
            else
              ovs_q <= ovs_q + 4'h1;
          end
          default:
            st_q <= S_IDLE;
        endcase
      end
    end
  end

  // Receive buffer: a push and a pop in one cycle leave the count as is
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N || !port_enable)
    begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      cnt_q    <= 2'b00;
      overrun_flag_q   <= 1'b0;
    end
    else
    begin
      if (push_ok)
      begin
        mem_q[wr_ptr_q] <= {~maj, shf_q};
        wr_ptr_q        <= wr_ptr_q + 1'b1;
      end
      if (pop)
        rd_ptr_q <= rd_ptr_q + 1'b1;
      case ({push_ok, pop})
        2'b10:   cnt_q <= cnt_q + 2'b01;
        2'b01:   cnt_q <= cnt_q - 2'b01;
        default: cnt_q <= cnt_q;
      endcase
      // A third character beats a receive-enable clear in the same cycle
      if (over)
        overrun_flag_q <= 1'b1;
      else if (!rxc_q[`ASR_RX_CONTINUOUS_RX_ENABLE])
        overrun_flag_q <= 1'b0;
    end
  end

  // Register writes
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      txc_q    <= `ASR_TX_RST;
      rxc_q    <= 8'h00;
      baud_q   <= `ASR_BC_RST;
      intc_q   <= 8'h00;
      ien_q    <= 8'h00;
      div_lo_q <= 8'h00;
      div_hi_q <= 8'h00;
    end
    else
    begin
      // No transmit path here: a break completes at once and the shifter
      // stays empty
      txc_q[`ASR_TX_BRK]  <= 1'b0;
      txc_q[`ASR_TX_SHIFTER_EMPTY_STATUS] <= 1'b1;
      baud_q[`ASR_BC_IDLE] <= rx_idle;
      if (wr_txc)
      begin
        txc_q[7:2] <= I_WB_DAT[7:2];
        // Break is only taken in asynchronous mode
        txc_q[`ASR_TX_BRK] <= I_WB_DAT[`ASR_TX_BRK] &
                              ~I_WB_DAT[`ASR_TX_SYNC];
        txc_q[`ASR_TX_TX_NINTH_BIT] <= I_WB_DAT[`ASR_TX_TX_NINTH_BIT];
      end
      if (wr_rxc)
        rxc_q[7:3] <= I_WB_DAT[7:3];
      if (wr_baud)
        baud_q[`ASR_BC_WIDE] <= I_WB_DAT[`ASR_BC_WIDE];
      if (wr_intc)
        intc_q <= I_WB_DAT[7:0];
      if (wr_ien)
        ien_q <= I_WB_DAT[7:0];
      if (wr_dlo)
        div_lo_q <= I_WB_DAT[7:0];
      if (wr_dhi)
        div_hi_q <= I_WB_DAT[7:0];
    end
  end

  // Read mux and one-cycle acknowledge
  always @(posedge I_REF_CLK)
  begin
    if (!I_RST_N)
    begin
      O_WB_ACK <= 1'b0;
      O_WB_DAT <= 32'h0000_0000;
    end
    else
    begin
      O_WB_ACK <= wb_req;
      O_WB_DAT <= 32'h0000_0000;
      if (rd)
      begin
        case (I_WB_ADR)
          `ASR_ADR_BAUD_CTRL: O_WB_DAT[7:0] <= baud_q;
          `ASR_ADR_INT_CTRL:  O_WB_DAT[7:0] <= intc_q;
          `ASR_ADR_IRQ_EN1:   O_WB_DAT[7:0] <= ien_q;
          `ASR_ADR_IRQ_FLG1:  O_WB_DAT[`ASR_FL_RX_PENDING_FLAG] <= pend;
          `ASR_ADR_RX_DATA:   O_WB_DAT[7:0] <= pend ? top[7:0] : 8'h00;
          `ASR_ADR_RX_STAT:   O_WB_DAT[7:0] <= rx_stat;
          `ASR_ADR_DIV_LO:    O_WB_DAT[7:0] <= div_lo_q;
          `ASR_ADR_DIV_HI:    O_WB_DAT[7:0] <= div_hi_q;
          `ASR_ADR_TX_STAT:   O_WB_DAT[7:0] <= txc_q;
          default:            O_WB_DAT <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // asr_top

// ---- verification/asr_properties.sv ----
// Bus and mode-output assertions for the receiver block
`timescale 1ns/1ps
module asr_props (
  // Clock, reset and bus
  input wire logic        I_REF_CLK,
  input wire logic        I_RST_N,
  input wire logic        I_WB_CYC,
  input wire logic        I_WB_STB,
  input wire logic        I_WB_WE,
  input wire logic [7:0]  I_WB_ADR,
  input wire logic [3:0]  I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  input wire logic [31:0] O_WB_DAT,
  input wire logic        O_WB_ACK,
  // Mode outputs
  input wire logic        O_TX_ENABLE,
  input wire logic        O_SYNC_MASTER,
  input wire logic        O_HIGH_SPEED
);
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);
  wire req = I_WB_CYC && I_WB_STB;
  // Write data is still held at the ack edge
  sequence tx_wr;
    req && I_WB_WE && I_WB_SEL[0] && I_WB_ADR == 8'h20 && !O_WB_ACK
      ##1 O_WB_ACK;
  endsequence
  sequence rd_ack;
    O_WB_ACK && !I_WB_WE;
  endsequence
  a_ack_answer: assert property (req && !O_WB_ACK |=> O_WB_ACK)
    else $error("request not acked");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack too long");
  a_ack_cause: assert property (!req |=> !O_WB_ACK)
    else $error("ack without request");
  a_unmapped_zero: assert property (
    rd_ack ##0 (I_WB_ADR > 8'h20) |-> O_WB_DAT == 32'h0)
    else $error("unmapped read not zero");
  a_tx_status_bits: assert property (
    rd_ack ##0 (I_WB_ADR == 8'h20) |-> O_WB_DAT[1] && !O_WB_DAT[3])
    else $error("transmit status bits wrong");
  a_speed_mode: assert property (
    tx_wr |-> O_HIGH_SPEED == (!I_WB_DAT[4] && I_WB_DAT[2]))
    else $error("high speed output wrong");
  a_master_mode: assert property (
    tx_wr |-> O_SYNC_MASTER == (I_WB_DAT[4] && I_WB_DAT[7]))
    else $error("master output wrong");
  a_tx_enable: assert property (
    tx_wr ##0 !I_WB_DAT[4] |-> O_TX_ENABLE == I_WB_DAT[5])
    else $error("transmit enable wrong");
  a_mode_excl: assert property (O_SYNC_MASTER |-> !O_HIGH_SPEED)
    else $error("sync and async outputs both set");
endmodule // asr_props
bind asr_top asr_props u_props (.*);

// ---- verification/asr_line_model.sv ----
// Remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module asr_line_model #(
  parameter int BIT = 16
) (
  // Clock and serial line
  input  wire logic i_clk,
  output logic      o_line
);
  initial o_line = 1'b1;
  // Start, data LSB first, stop; line idles high after the frame
  task automatic send(input logic [8:0] d, input bit nine, input bit stp);
    logic [10:0] f;
    f = {stp, d, 1'b0};
    if (!nine)
      f[9] = stp;
    for (int i = 0; i < (nine ? 11 : 10); i++)
      repeat (BIT) @(posedge i_clk) o_line <= f[i];
    @(posedge i_clk) o_line <= 1'b1;
  endtask
  // Low pulse that is gone well before mid start bit
  task automatic glitch(input int n);
    repeat (n) @(posedge i_clk) o_line <= 1'b0;
    @(posedge i_clk) o_line <= 1'b1;
  endtask
endmodule // asr_line_model

// ---- verification/tb_top.sv ----
// Self-checking bench for the asynchronous serial receiver block
`timescale 1ns/1ps
module tb_top;
  localparam int DIV = 0;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h0;
  logic [7:0]  wd = 8'h0;
  logic [31:0] rdat;
  logic        ack, irq, txe, smas, hspd, rx;
  logic [7:0]  q, d;
  int          bad_count = 0;
  int          n_tests = 0;
  int          seed = 32'h02eb_2c3f;

  asr_top DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'h1),
    .I_WB_DAT({24'h0, wd}), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_RX(rx),
    .O_IRQ(irq), .O_TX_ENABLE(txe), .O_SYNC_MASTER(smas),
    .O_HIGH_SPEED(hspd));
  asr_line_model #(.BIT(16 * (DIV + 1))) line (.i_clk(clk), .o_line(rx));

  initial forever #25 clk = ~clk;

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Classic cycle: hold everything until ack is seen at an edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    int k;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= v;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (ack !== 1'b1 && k < 20);
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (k >= 20)
    begin
      bad_count++;
      complete_run;
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h0);
    chk(q, e);
  endtask

  task automatic rx_char(input logic [8:0] c, input bit nine, input bit stp);
    line.send(c, nine, stp);
    repeat (8) @(posedge clk);
  endtask

  // Break never reads back set, shifter always reads empty
  function automatic logic [7:0] tx_exp(input logic [7:0] v);
    return {v[7:4], 1'b0, v[2], 1'b1, v[0]};
  endfunction

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rc(8'h20, 8'h02);
    rc(8'h00, 8'h40);
    rc(8'h14, 8'h00);
    bus(1'b1, 8'h24, 8'hff);
    rc(8'h24, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 12; i++)
    begin
      d = (i == 0) ? 8'hff : (i == 1) ? 8'h08 : 8'($random(seed));
      bus(1'b1, 8'h20, d);
      rc(8'h20, tx_exp(d));
      chk({5'h0, smas, hspd, txe}, {5'h0, d[7] & d[4], d[2] & ~d[4], d[5]});
    end
    bus(1'b1, 8'h14, 8'h90);
    bus(1'b1, 8'h20, 8'h30);
    chk({7'h0, txe}, 8'h00);
    $display("test transmit control done");
    bus(1'b1, 8'h18, 8'h00);
    bus(1'b1, 8'h20, 8'h00);
    bus(1'b1, 8'h14, 8'h80);
    bus(1'b1, 8'h04, 8'hc0);
    bus(1'b1, 8'h14, 8'h90);
    for (int i = 0; i < 4; i++)
    begin
      d = 8'($random(seed));
      bus(1'b1, 8'h08, i[0] ? 8'h20 : 8'h00);
      rx_char({1'b0, d}, 0, 1);
      chk({7'h0, irq}, {7'h0, i[0]});
      rc(8'h0c, 8'h20);
      rc(8'h14, 8'h90);
      rc(8'h10, d);
      rc(8'h0c, 8'h00);
    end
    rx_char(9'h055, 0, 0);
    rc(8'h14, 8'h94);
    rc(8'h10, 8'h55);
    line.glitch(4);
    repeat (200) @(posedge clk);
    rc(8'h0c, 8'h00);
    $display("test eight bit done");
    bus(1'b1, 8'h14, 8'hd0);
    rx_char(9'h1a5, 1, 1);
    rc(8'h14, 8'hd1);
    rc(8'h10, 8'ha5);
    bus(1'b1, 8'h14, 8'hd8);
    rx_char(9'h033, 1, 1);
    rc(8'h0c, 8'h00);
    rx_char(9'h142, 1, 1);
    rc(8'h14, 8'hd9);
    rc(8'h10, 8'h42);
    bus(1'b1, 8'h14, 8'hd0);
    rx_char(9'h077, 1, 1);
    rc(8'h0c, 8'h20);
    rc(8'h14, 8'hd0);
    rc(8'h10, 8'h77);
    $display("test address detect done");
    rx_char(9'h011, 1, 1);
    rx_char(9'h022, 1, 1);
    rx_char(9'h033, 1, 1);
    rc(8'h14, 8'hd2);
    rc(8'h10, 8'h11);
    rc(8'h10, 8'h22);
    rc(8'h0c, 8'h00);
    bus(1'b1, 8'h14, 8'hc0);
    rc(8'h14, 8'hc0);
    $display("test overrun done");
    complete_run;
  end
endmodule // tb_top
